// [rtl/gtgc_pkg.sv]
// Package: register map, field positions and types of the gated timer block
package gtgc_pkg;
  // -------------------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // -------------------------------------------------------------------------
  localparam logic [3:0] GTGC_OFS_GATE_CTRL = 4'h0;
  localparam logic [3:0] GTGC_OFS_COUNT_LO = 4'h4;
  localparam logic [3:0] GTGC_OFS_COUNT_HI = 4'h8;
  localparam logic [3:0] GTGC_OFS_SETUP = 4'hC;

  // -------------------------------------------------------------------------
  // Gate control fields
  // -------------------------------------------------------------------------
  localparam int GTGC_B_GE = 7;
  localparam int GTGC_B_POL = 6;
  localparam int GTGC_B_TGL = 5;
  localparam int GTGC_B_SPM = 4;
  localparam int GTGC_B_ARM = 3;
  localparam int GTGC_B_VAL = 2;

  // Setup fields: source select, comparator sync, irq enable, flag, async
  localparam int GTGC_B_SRC_LO = 0;
  localparam int GTGC_B_SRC_HI = 1;
  localparam int GTGC_B_CSYNC = 2;
  localparam int GTGC_B_IRQEN = 3;
  localparam int GTGC_B_FLAG = 4;
  localparam int GTGC_B_ASYNC = 5;

  localparam logic [7:0] GTGC_RST_BYTE = 8'h00;
  localparam logic [15:0] GTGC_RST_COUNT = 16'h0000;
  localparam logic [31:0] GTGC_RD_ZERO = 32'h0000_0000;

  // Gate source encoding
  typedef enum logic [1:0] {
    GTGC_SRC_PIN = 2'h0,
    GTGC_SRC_TMR = 2'h1,
    GTGC_SRC_CMP1 = 2'h2,
    GTGC_SRC_CMP2 = 2'h3
  } gtgc_src_t;

  // Raw gate inputs travel together
  typedef struct packed {
    logic pin;
    logic tmr_ovf;
    logic cmp1;
    logic cmp2;
  } gtgc_gate_in_t;

  // Software control state
  typedef struct packed {
    logic ge;
    logic pol;
    logic tgl;
    logic spm;
    logic arm;
    gtgc_src_t src;
    logic csync;
    logic irqen;
    logic async_ext;
  } gtgc_ctrl_t;
endpackage : gtgc_pkg

// [rtl/gtgc_counter.sv]
// Sixteen-bit counter register pair with byte loads and overflow pulse
`timescale 1ns/1ps
module gtgc_counter import gtgc_pkg::*; #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic inc,
  input wire logic load_lo,
  input wire logic load_hi,
  input wire logic [7:0] wdata,
  output logic [WIDTH-1:0] count,
  output logic ovf
);
  logic [WIDTH-1:0] next_count;
  logic next_ovf;

  always_comb begin
    next_count = count;
    next_ovf = 1'b0;
    if (inc) begin
      next_count = count + 1'b1; // R1
      next_ovf = &count;
    end
    // A byte load wins over an increment for that byte in the same cycle; a carry into the other byte is kept
    if (load_lo) begin
      next_count[7:0] = wdata;
    end
    if (load_hi) begin
      next_count[WIDTH-1:8] = wdata[WIDTH-9:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= GTGC_RST_COUNT[WIDTH-1:0];
      ovf <= 1'b0;
    end else begin
      count <= next_count;
      ovf <= next_ovf;
    end
  end
endmodule : gtgc_counter

// [rtl/gtgc_top.sv]
// Gate control logic of a 16-bit timer with Avalon-MM register slave
//
// Overview of operation
// (R1) Sixteen-bit counter, read and written as low and high byte.
// (R2) Gate source chosen from several signals by the source select field.
// (R3) Polarity bit clear inverts whichever gate source is chosen; set passes it through.
// (R4) External gate pin is one selectable source.
// (R5) Companion timer overflow makes a rising pulse used as gate source.
// (R6) Either comparator selectable, synchronised or used directly.
// (R7) Toggle mode flips a flip-flop on each rising gate edge.
// (R8) Toggle flip-flop held clear while toggle enable is clear.
// (R9) Software should not enable toggle while changing polarity.
// (R10) Single-pulse: set enable, then arm; counting starts at next rise.
// (R11) Arm bit clears itself on the trailing gate edge.
// (R12) After acquisition no gate event counts until armed again.
// (R13) Software should clear arm when disabling single-pulse mode.
// (R14) Hardware clears arm whenever single-pulse enable is clear.
// (R15) Toggle and single-pulse together capture one full gate cycle.
// (R16) Gate level status readable, valid even with gate enable clear.
// (R17) Falling edge of gate level status sets the gate event flag.
// (R18) Flag and its enable both set raise the interrupt request.
// (R19) Flag keeps being set while gate enable is clear.
// (R20) Overflow wakes from sleep only in external asynchronous mode.
// (R21) Gate enable clear lets counter increment every timer clock.
// (R22) Reset clears the five writable bits; low two bits read zero.
`timescale 1ns/1ps
module gtgc_top import gtgc_pkg::*; #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer_tick,
  input wire logic sleep_mode,
  input wire logic external_gate_pin,
  input wire logic tmr_ovf_in,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  output logic gate_irq,
  output logic overflow_wake
);
  // -------------------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------------------
  logic rst_s1, rst_s2;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // -------------------------------------------------------------------------
  // Gate source path
  // -------------------------------------------------------------------------
  gtgc_gate_in_t gin;
  gtgc_ctrl_t ctrl, next_ctrl;
  logic cmp1_s, cmp2_s, cmp1_m, cmp2_m, tmr_ovf_q, tmr_pulse;
  logic src_raw, gate_pol, gate_pol_q, tgl_ff, next_tgl_ff;
  logic gate_level, gate_level_q, span_active, next_span_active;
  logic flag, next_flag, flag_clr;
  logic gate_rise, gate_fall, pol_rise, count_en;

  assign gin = '{pin: external_gate_pin, tmr_ovf: tmr_ovf_in,
                 cmp1: cmp1_out, cmp2: cmp2_out};

  // Rising edge of companion overflow becomes a one-cycle pulse
  assign tmr_pulse = gin.tmr_ovf & ~tmr_ovf_q; // R5

  always_comb begin
    unique case (ctrl.src) // R2
      GTGC_SRC_PIN: src_raw = gin.pin; // R4
      GTGC_SRC_TMR: src_raw = tmr_pulse; // R5
      GTGC_SRC_CMP1: src_raw = ctrl.csync ? cmp1_s : gin.cmp1; // R6
      GTGC_SRC_CMP2: src_raw = ctrl.csync ? cmp2_s : gin.cmp2; // R6
    endcase
  end

  assign gate_pol = src_raw ^ ~ctrl.pol; // R3
  assign pol_rise = gate_pol & ~gate_pol_q;

  // Toggle stage follows whole gate cycles; cleared while disabled
  always_comb begin
    next_tgl_ff = tgl_ff;
    if (!ctrl.tgl) begin
      next_tgl_ff = 1'b0; // R8
    end else if (pol_rise) begin
      next_tgl_ff = ~tgl_ff; // R7
    end
  end

  // Gate level seen by the counter, before gate enable applies
  assign gate_level = ctrl.tgl ? tgl_ff : gate_pol; // R7
  assign gate_rise = gate_level & ~gate_level_q;
  assign gate_fall = ~gate_level & gate_level_q;

  // -------------------------------------------------------------------------
  // Single-pulse control and count enable
  // -------------------------------------------------------------------------

  // In single-pulse mode counting needs an armed span begun on a rising edge
  always_comb begin
    next_span_active = span_active;
    if (!ctrl.spm || !ctrl.arm) begin
      next_span_active = 1'b0; // R12
    end else if (gate_rise) begin
      next_span_active = 1'b1; // R10 R15
    end
  end

  always_comb begin
    if (!ctrl.ge) begin
      count_en = timer_tick; // R21
    end else if (ctrl.spm) begin
      count_en = timer_tick & gate_level & (span_active | gate_rise)
                 & ctrl.arm; // R10 R12
    end else begin
      count_en = timer_tick & gate_level;
    end
  end

  // Clear first, then set, so a gate event in the clear cycle is kept
  always_comb begin
    next_flag = flag;
    if (flag_clr) begin
      next_flag = 1'b0;
    end
    if (gate_fall) begin
      next_flag = 1'b1; // R17 R19
    end
  end

  // Two stages on comparator inputs; the second feeds the mux
  always_ff @(posedge sys_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      cmp1_s <= 1'b0;
      cmp2_s <= 1'b0;
      tmr_ovf_q <= 1'b0;
      gate_pol_q <= 1'b0;
      tgl_ff <= 1'b0;
      gate_level_q <= 1'b0;
      span_active <= 1'b0;
      flag <= 1'b0;
    end else begin
      cmp1_s <= cmp1_m;
      cmp2_s <= cmp2_m;
      tmr_ovf_q <= gin.tmr_ovf;
      gate_pol_q <= gate_pol;
      tgl_ff <= next_tgl_ff;
      gate_level_q <= gate_level;
      span_active <= next_span_active;
      flag <= next_flag;
    end
  end

  // First stage feeds only the second, keeping metastability off the mux
  always_ff @(posedge sys_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      cmp1_m <= 1'b0;
      cmp2_m <= 1'b0;
    end else begin
      cmp1_m <= gin.cmp1;
      cmp2_m <= gin.cmp2;
    end
  end

  // -------------------------------------------------------------------------
  // Counter
  // -------------------------------------------------------------------------
  logic [WIDTH-1:0] count;
  logic ovf, load_lo, load_hi, wr_acc, rd_acc;

  gtgc_counter #(.WIDTH(WIDTH)) u_counter (
    .sys_clk(sys_clk),
    .rst_n(rst_s2),
    .inc(count_en),
    .load_lo(load_lo),
    .load_hi(load_hi),
    .wdata(avs_writedata[7:0]),
    .count(count),
    .ovf(ovf)
  );

  // -------------------------------------------------------------------------
  // Register slave: one wait cycle, then answer
  // -------------------------------------------------------------------------
  logic pend, next_pend;
  logic [31:0] next_rdata;
  logic next_irq, next_wake;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction : hit

  assign wr_acc = avs_write & pend & avs_byteenable[0];
  // Read data is registered at the edge that takes the request, so it
  // stands in the same cycle as the low waitrequest
  assign rd_acc = avs_read & ~pend;
  assign load_lo = wr_acc & hit(avs_address, GTGC_OFS_COUNT_LO); // R1
  assign load_hi = wr_acc & hit(avs_address, GTGC_OFS_COUNT_HI); // R1
  assign flag_clr = wr_acc & hit(avs_address, GTGC_OFS_SETUP)
                    & ~avs_writedata[GTGC_B_FLAG];
  // A request is taken only from idle; the answer cycle never re-takes it
  assign next_pend = (avs_read | avs_write) & ~pend;

  always_comb begin
    next_ctrl = ctrl;
    if (wr_acc && hit(avs_address, GTGC_OFS_GATE_CTRL)) begin
      next_ctrl.ge = avs_writedata[GTGC_B_GE];
      next_ctrl.pol = avs_writedata[GTGC_B_POL];
      next_ctrl.tgl = avs_writedata[GTGC_B_TGL];
      next_ctrl.spm = avs_writedata[GTGC_B_SPM];
      next_ctrl.arm = avs_writedata[GTGC_B_ARM];
    end
    if (wr_acc && hit(avs_address, GTGC_OFS_SETUP)) begin
      next_ctrl.src = gtgc_src_t'(
        avs_writedata[GTGC_B_SRC_HI:GTGC_B_SRC_LO]);
      next_ctrl.csync = avs_writedata[GTGC_B_CSYNC];
      next_ctrl.irqen = avs_writedata[GTGC_B_IRQEN];
      next_ctrl.async_ext = avs_writedata[GTGC_B_ASYNC];
    end
    // Hardware clear beats a software set in the same cycle
    if (ctrl.spm && ctrl.arm && span_active && gate_fall) begin
      next_ctrl.arm = 1'b0; // R11 R15
    end
    if (!next_ctrl.spm) begin
      next_ctrl.arm = 1'b0; // R14
    end
  end

  always_comb begin
    next_rdata = GTGC_RD_ZERO;
    if (rd_acc) begin
      unique case (avs_address)
        GTGC_OFS_GATE_CTRL: begin
          next_rdata[GTGC_B_GE] = ctrl.ge;
          next_rdata[GTGC_B_POL] = ctrl.pol;
          next_rdata[GTGC_B_TGL] = ctrl.tgl;
          next_rdata[GTGC_B_SPM] = ctrl.spm;
          next_rdata[GTGC_B_ARM] = ctrl.arm;
          next_rdata[GTGC_B_VAL] = gate_level; // R16 R22
        end
        GTGC_OFS_COUNT_LO: next_rdata[7:0] = count[7:0]; // R1
        GTGC_OFS_COUNT_HI: next_rdata[7:0] = 8'(count[WIDTH-1:8]); // R1
        GTGC_OFS_SETUP: begin
          next_rdata[GTGC_B_SRC_HI:GTGC_B_SRC_LO] = ctrl.src;
          next_rdata[GTGC_B_CSYNC] = ctrl.csync;
          next_rdata[GTGC_B_IRQEN] = ctrl.irqen;
          next_rdata[GTGC_B_FLAG] = flag;
          next_rdata[GTGC_B_ASYNC] = ctrl.async_ext;
        end
        default: next_rdata = GTGC_RD_ZERO;
      endcase
    end
  end

  // Built from next values so the request tracks the flag with no lag
  assign next_irq = next_flag & next_ctrl.irqen; // R18
  // Wake matters only while the counter runs from its own async clock
  assign next_wake = ovf & sleep_mode & ctrl.async_ext; // R20

  // -------------------------------------------------------------------------
  // Control state and registered outputs
  // -------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      ctrl <= '{ge: 1'b0, pol: 1'b0, tgl: 1'b0, spm: 1'b0, arm: 1'b0,
                src: GTGC_SRC_PIN, csync: 1'b0, irqen: 1'b0,
                async_ext: 1'b0}; // R22
      pend <= 1'b0;
      avs_readdata <= GTGC_RD_ZERO;
      gate_irq <= 1'b0;
      overflow_wake <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      pend <= next_pend;
      avs_readdata <= next_rdata;
      gate_irq <= next_irq;
      overflow_wake <= next_wake;
    end
  end

  // Waitrequest is high at rest, drops for one cycle after a request lands
  logic next_wait;
  assign next_wait = ~next_pend;
  always_ff @(posedge sys_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= next_wait;
    end
  end
endmodule : gtgc_top

// [dv/gtgc_properties.sv]
// Port-level checks for the gated timer gate control block
`timescale 1ns/1ps
module gtgc_properties import gtgc_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input wire logic sleep_mode,
  input logic gate_irq,
  input logic overflow_wake
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  a_req_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_ack_has_req: assert property (
    !avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("ack without request");
  a_rd_idle_zero: assert property (
    avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("readdata not zero at rest");
  a_rd_byte_wide: assert property (
    !avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h0)
    else $error("upper lanes set");
  a_ctrl_pad_zero: assert property (
    !avs_waitrequest && avs_read && avs_address == GTGC_OFS_GATE_CTRL
    |-> avs_readdata[1:0] == 2'h0)
    else $error("pad bits set");
  // ------------------------------------------------------------------
  // Event outputs
  // ------------------------------------------------------------------
  a_wake_pulse: assert property (
    overflow_wake |=> !overflow_wake)
    else $error("wake longer than one cycle");
  a_wake_asleep: assert property (
    overflow_wake |-> $past(sleep_mode))
    else $error("wake while awake");
  // Only a software write can take the request away
  a_irq_fall_write: assert property (
    $fell(gate_irq) |-> $past(avs_write && !avs_waitrequest)
    || $past(avs_write && !avs_waitrequest, 2))
    else $error("irq dropped without write");
endmodule : gtgc_properties

bind gtgc_top gtgc_properties chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sleep_mode(sleep_mode), .gate_irq(gate_irq),
  .overflow_wake(overflow_wake));

// [dv/gtgc_gate_model.sv]
// Behavioural gate sources: pin, companion overflow, two comparators
`timescale 1ns/1ps
module gtgc_gate_model import gtgc_pkg::*; (
  input wire logic sys_clk,
  input wire logic [1:0] sel,
  input wire logic lvl,
  output gtgc_gate_in_t gate
);
  logic lvl_q = 1'b0;
  always @(posedge sys_clk) lvl_q <= lvl;
  // Unselected pin and comparator sources show the opposite level so a wrong mux shows up; unselected overflow stays low
  always_comb begin
    gate.pin = (sel == GTGC_SRC_PIN) ? lvl : ~lvl;
    gate.tmr_ovf = (sel == GTGC_SRC_TMR) && lvl && !lvl_q;
    gate.cmp1 = (sel == GTGC_SRC_CMP1) ? lvl : ~lvl;
    gate.cmp2 = (sel == GTGC_SRC_CMP2) ? lvl : ~lvl;
  end
endmodule : gtgc_gate_model

// [dv/gated_timer_gate_control_bench.sv]
// Self-checking bench for the gated timer gate control block
`timescale 1ns/1ps
module gated_timer_gate_control_bench import gtgc_pkg::*;;
  logic sys_clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic tick = 1'b0, slp = 1'b0, lvl = 1'b1, irq, wtr, wake;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] sel = 2'h0;
  logic [7:0] q;
  gtgc_gate_in_t g;
  int n_mismatch = 0, cmp_count = 0, nw = 0, i, s, p, v;

  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wake === 1'b1) nw <= nw + 1;

  gtgc_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wtr),
    .timer_tick(tick), .sleep_mode(slp), .external_gate_pin(g.pin),
    .tmr_ovf_in(g.tmr_ovf), .cmp1_out(g.cmp1), .cmp2_out(g.cmp2),
    .gate_irq(irq), .overflow_wake(wake));
  gtgc_gate_model pm_u (.sys_clk(sys_clk), .sel(sel), .lvl(lvl), .gate(g));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [7:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {24'h0, d};
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (wtr === 1'b0) break;
    end
    if (i == 20) begin
      n_mismatch++;
      report_and_stop();
    end
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : wrr

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(q, e);
  endtask : rdc

  task automatic ticks(input int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge sys_clk);
    end
    tick <= 1'b0;
    @(posedge sys_clk);
  endtask : ticks

  // Four cycles covers the comparator synchroniser
  task automatic gl(input logic x);
    lvl <= x;
    repeat (4) @(posedge sys_clk);
  endtask : gl

  task automatic wirq(input logic e);
    for (i = 0; i < 20 && irq !== e; i++) @(posedge sys_clk);
    chk({7'h0, irq}, {7'h0, e});
  endtask : wirq

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (s = 0; s < 16; s += 4) rdc(4'(s), 8'h00);
    wrr(4'h2, 8'hFF);
    rdc(4'h2, 8'h00);
    rdc(4'h0, 8'h00);
    wrr(4'h4, 8'hFE);
    wrr(4'h8, 8'h12);
    ticks(3);
    rdc(4'h4, 8'h01);
    rdc(4'h8, 8'h13);
    wrr(4'hC, 8'h20);
    slp <= 1'b1;
    wrr(4'h4, 8'hFF);
    wrr(4'h8, 8'hFF);
    ticks(1);
    rdc(4'h8, 8'h00);
    chk(8'(nw), 8'h01);
    wrr(4'hC, 8'h00);
    wrr(4'h4, 8'hFF);
    wrr(4'h8, 8'hFF);
    ticks(1);
    rdc(4'h4, 8'h00);
    chk(8'(nw), 8'h01);
    slp <= 1'b0;
    for (s = 0; s < 4; s++) if (s != 1) for (p = 0; p < 2; p++)
      for (v = 0; v < 2; v++) begin
        sel <= 2'(s);
        wrr(4'hC, 8'(s | (p << 2)));
        wrr(4'h0, 8'(p << 6));
        gl(1'(v));
        rdc(4'h0, 8'((p << 6) | ((v == p) << 2)));
      end
    sel <= 2'h0;
    wrr(4'hC, 8'h00);
    gl(1'b1);
    wrr(4'hC, 8'h08);
    wirq(1'b0);
    gl(1'b0);
    wirq(1'b1);
    rdc(4'hC, 8'h18);
    wrr(4'hC, 8'h00);
    wirq(1'b0);
    gl(1'b1);
    gl(1'b0);
    rdc(4'hC, 8'h10);
    wirq(1'b0);
    wrr(4'hC, 8'h00);
    wrr(4'h0, 8'hC0);
    wrr(4'h4, 8'h00);
    wrr(4'h8, 8'h00);
    ticks(5);
    rdc(4'h4, 8'h00);
    gl(1'b1);
    ticks(5);
    rdc(4'h4, 8'h05);
    wrr(4'h0, 8'h60);
    rdc(4'h0, 8'h60);
    gl(1'b0);
    gl(1'b1);
    rdc(4'h0, 8'h64);
    gl(1'b0);
    rdc(4'h0, 8'h64);
    gl(1'b1);
    rdc(4'h0, 8'h60);
    wrr(4'h0, 8'h40);
    rdc(4'h0, 8'h44);
    wrr(4'h0, 8'h60);
    rdc(4'h0, 8'h60);
    sel <= 2'h1;
    wrr(4'hC, 8'h01);
    gl(1'b0);
    gl(1'b1);
    rdc(4'h0, 8'h64);
    sel <= 2'h0;
    wrr(4'hC, 8'h00);
    gl(1'b0);
    wrr(4'h0, 8'hD0);
    wrr(4'h0, 8'hD8);
    rdc(4'h0, 8'hD8);
    wrr(4'h4, 8'h00);
    wrr(4'h8, 8'h00);
    ticks(3);
    gl(1'b1);
    ticks(3);
    gl(1'b0);
    rdc(4'h0, 8'hD0);
    gl(1'b1);
    ticks(3);
    rdc(4'h4, 8'h03);
    wrr(4'h0, 8'hD8);
    wrr(4'h0, 8'hC8);
    rdc(4'h0, 8'hC4);
    wrr(4'h0, 8'hD8);
    wrr(4'h0, 8'hC0);
    rdc(4'h0, 8'hC4);
    wrr(4'h0, 8'hF0);
    wrr(4'h0, 8'hF8);
    wrr(4'h4, 8'h00);
    wrr(4'h8, 8'h00);
    gl(1'b0);
    gl(1'b1);
    ticks(2);
    gl(1'b0);
    ticks(2);
    gl(1'b1);
    ticks(2);
    rdc(4'h4, 8'h04);
    rdc(4'h0, 8'hF0);
    report_and_stop();
  end
endmodule : gated_timer_gate_control_bench
